// >>> hdl/aspsl_top.sv
// Purpose: Asynchronous serial transmitter and receiver with sleep filter
// Assumes: Inputs synchronous to sys_clk; sync mode codes not supported
// Notes: Flags are plain ports; software strobes are one-cycle pulses
// Notes on behaviour
// - Mode bit 6 enables parity both ways
// - Control0 bit2 chooses permit input or ready output
// - Start needs enable, buffer full, permit low
// - Shift LSB first with parity, stop bits
// - Buffer write clears empty; load sets it
// - Buffer reloads shifter automatically after frame
// - Started frame ignores enable, flag, permit
// - Start checked during frame end; back to back
// - Shift empty sets after frame end, clears start
// - Empty flag rising raises transmit request
// - Receiver divider starts on start bit
// - Ready output high, low on enable, high receiving
// - Last bit copies shifter to buffer, sets full
// - Full flag rising raises receive request
// - Overrun when transfer finds full set and no low read in that cycle
// - Framing error on missing stop bits
// - Parity error on parity mismatch
// - Summary flag ORs the three errors
// - Receive flags set only at transfer
// - Errors clear on low read or disable
// - Mode bit 7 enables sleep mode
// - Sleep drops frames with top bit zero
// - Mode bits 0 to 2 pick length
// - Mode bit 4 picks stop bit count
// - Mode bit 5 picks odd or even
// - Clock divided by value plus one, sixteen
`timescale 1ns/10ps
`default_nettype none
`include "aspsl_regs.svh"
module aspsl_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] mode_reg,
    input wire logic handshake_sel,
    input wire logic tx_enable_flag,
    input wire logic rx_enable_flag,
    input wire logic ext_clk_sel,
    input wire logic ext_clk_tick,
    input wire logic [7:0] bit_rate_value,
    input wire logic [8:0] tx_buffer_data,
    input wire logic tx_buffer_write,
    input wire logic rx_buffer_low_read,
    input wire logic send_permit_input,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic receive_ready_output,
    output logic tx_buffer_empty_flag,
    output logic tx_shift_empty_flag,
    output logic frame_end_timing,
    output logic [8:0] rx_buffer_data,
    output logic rx_buffer_full_flag,
    output logic overrun_flag,
    output logic framing_error_flag,
    output logic parity_error_flag,
    output logic error_summary_flag,
    output logic tx_irq_request,
    output logic rx_irq_request
);
    // ==========================================
    // Format decode
    logic [3:0] data_bits;
    logic par_en;
    logic par_even;
    logic two_stop;
    logic [3:0] top_index;
    always_comb begin
        unique case (mode_reg[2:0])
            `ASPSL_MODE_LEN_7: data_bits = 4'h7;
            `ASPSL_MODE_LEN_9: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
        top_index = data_bits - 4'h1;
        par_en = mode_reg[`ASPSL_MODE_PAREN];
        par_even = mode_reg[`ASPSL_MODE_EVEN];
        two_stop = mode_reg[`ASPSL_MODE_STOP2];
    end
    // ==========================================
    // Bit rate prescaler
    logic [7:0] rate_cnt;
    logic src_tick;
    logic os_tick;
    assign src_tick = ext_clk_sel ? ext_clk_tick : 1'b1;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rate_cnt <= 8'h00;
            os_tick <= 1'b0;
        end else begin
            os_tick <= 1'b0;
            if (src_tick) begin
                if (rate_cnt == 8'h00) begin
                    rate_cnt <= bit_rate_value;
                    os_tick <= 1'b1;
                end else begin
                    rate_cnt <= rate_cnt - 8'h01;
                end
            end
        end
    end
    // ==========================================
    // Transmitter
    aspsl_pkg::aspsl_phase_t tx_phase;
    logic [3:0] tx_os;
    logic [3:0] tx_idx;
    logic [8:0] tx_shift;
    logic [8:0] tx_hold;
    logic tx_par;
    logic tx_bit_end;
    logic tx_go;
    logic permit_ok;
    assign tx_bit_end = os_tick && (tx_os == `ASPSL_LAST_TICK);
    assign permit_ok = handshake_sel || !send_permit_input;
    assign tx_go = tx_enable_flag && !tx_buffer_empty_flag && permit_ok;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_hold <= 9'h000;
        end else if (tx_buffer_write) begin
            tx_hold <= tx_buffer_data;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_phase <= aspsl_pkg::ASPSL_IDLE;
            tx_os <= 4'h0;
            tx_idx <= 4'h0;
            tx_shift <= 9'h000;
            tx_par <= 1'b0;
            serial_out_pin <= 1'b1;
            frame_end_timing <= 1'b1;
        end else begin
            if (os_tick) begin
                tx_os <= tx_os + 4'h1;
            end
            unique case (tx_phase)
                aspsl_pkg::ASPSL_IDLE: begin
                    frame_end_timing <= 1'b1;
                    serial_out_pin <= 1'b1;
                    if (tx_go) begin
                        tx_shift <= tx_hold;
                        tx_par <= ~par_even;
                        tx_phase <= aspsl_pkg::ASPSL_START;
                        tx_os <= 4'h0;
                        serial_out_pin <= 1'b0;
                        frame_end_timing <= 1'b0;
                    end
                end
                aspsl_pkg::ASPSL_START: begin
                    if (tx_bit_end) begin
                        tx_phase <= aspsl_pkg::ASPSL_DATA;
                        tx_idx <= 4'h0;
                        serial_out_pin <= tx_shift[0];
                    end
                end
                aspsl_pkg::ASPSL_DATA: begin
                    if (tx_bit_end) begin
                        tx_par <= tx_par ^ tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[8:1]};
                        tx_idx <= tx_idx + 4'h1;
                        if (tx_idx == top_index) begin
                            tx_idx <= 4'h0;
                            if (par_en) begin
                                tx_phase <= aspsl_pkg::ASPSL_PARITY;
                                serial_out_pin <= tx_par ^ tx_shift[0];
                            end else begin
                                tx_phase <= aspsl_pkg::ASPSL_STOP;
                                serial_out_pin <= 1'b1;
                            end
                        end else begin
                            serial_out_pin <= tx_shift[1];
                        end
                    end
                end
                aspsl_pkg::ASPSL_PARITY: begin
                    if (tx_bit_end) begin
                        tx_phase <= aspsl_pkg::ASPSL_STOP;
                        serial_out_pin <= 1'b1;
                    end
                end
                aspsl_pkg::ASPSL_STOP: begin
                    if (tx_bit_end) begin
                        tx_idx <= tx_idx + 4'h1;
                        if (tx_idx == {3'h0, two_stop}) begin
                            tx_phase <= aspsl_pkg::ASPSL_IDLE;
                            frame_end_timing <= 1'b1;
                        end
                    end
                end
                default: tx_phase <= aspsl_pkg::ASPSL_IDLE;
            endcase
        end
    end
    // Load strobe: idle and start condition met
    logic tx_load;
    assign tx_load = (tx_phase == aspsl_pkg::ASPSL_IDLE) && tx_go;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_buffer_empty_flag <= 1'b1;
            tx_irq_request <= 1'b0;
        end else begin
            tx_irq_request <= 1'b0;
            if (tx_load) begin
                tx_buffer_empty_flag <= 1'b1;
                tx_irq_request <= 1'b1;
            end else if (tx_buffer_write) begin
                tx_buffer_empty_flag <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_shift_empty_flag <= 1'b1;
        end else if (tx_load) begin
            tx_shift_empty_flag <= 1'b0;
        end else if (frame_end_timing) begin
            tx_shift_empty_flag <= 1'b1;
        end
    end
    // ==========================================
    // Receiver
    aspsl_pkg::aspsl_phase_t rx_phase;
    logic [3:0] rx_os;
    logic [3:0] rx_idx;
    logic [8:0] rx_shift;
    logic rx_par;
    logic rx_stop_bad;
    logic rx_sample;
    logic rx_done;
    logic rx_keep;
    logic rx_par_bad;
    logic rx_frm_bad;
    assign rx_sample = os_tick && (rx_os == `ASPSL_HALF_BIT);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_phase <= aspsl_pkg::ASPSL_IDLE;
            rx_os <= 4'h0;
            rx_idx <= 4'h0;
            rx_shift <= 9'h000;
            rx_par <= 1'b0;
            rx_stop_bad <= 1'b0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (os_tick) begin
                rx_os <= rx_os + 4'h1;
            end
            unique case (rx_phase)
                aspsl_pkg::ASPSL_IDLE: begin
                    if (rx_enable_flag && !serial_in_pin) begin
                        rx_phase <= aspsl_pkg::ASPSL_START;
                        rx_os <= 4'h0;
                        rx_stop_bad <= 1'b0;
                    end
                end
                aspsl_pkg::ASPSL_START: begin
                    if (rx_sample) begin
                        if (serial_in_pin) begin
                            rx_phase <= aspsl_pkg::ASPSL_IDLE;
                        end else begin
                            rx_phase <= aspsl_pkg::ASPSL_DATA;
                            rx_idx <= 4'h0;
                            rx_shift <= 9'h000;
                            rx_par <= ~par_even;
                        end
                    end
                end
                aspsl_pkg::ASPSL_DATA: begin
                    if (rx_sample) begin
                        rx_shift[rx_idx] <= serial_in_pin;
                        rx_par <= rx_par ^ serial_in_pin;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == top_index) begin
                            rx_idx <= 4'h0;
                            rx_phase <= par_en ? aspsl_pkg::ASPSL_PARITY
                                               : aspsl_pkg::ASPSL_STOP;
                        end
                    end
                end
                aspsl_pkg::ASPSL_PARITY: begin
                    if (rx_sample) begin
                        rx_par <= rx_par ^ serial_in_pin;
                        rx_phase <= aspsl_pkg::ASPSL_STOP;
                    end
                end
                aspsl_pkg::ASPSL_STOP: begin
                    if (rx_sample) begin
                        rx_idx <= rx_idx + 4'h1;
                        if (!serial_in_pin) begin
                            rx_stop_bad <= 1'b1;
                        end
                        if (rx_idx == {3'h0, two_stop}) begin
                            rx_phase <= aspsl_pkg::ASPSL_IDLE;
                            rx_done <= 1'b1;
                        end
                    end
                end
                default: rx_phase <= aspsl_pkg::ASPSL_IDLE;
            endcase
        end
    end
    // Last stop sample already held in rx_stop_bad when rx_done is high
    assign rx_frm_bad = rx_stop_bad;
    assign rx_par_bad = par_en && rx_par;
    assign rx_keep = !mode_reg[`ASPSL_MODE_SLEEP] || rx_shift[top_index];
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_buffer_data <= 9'h000;
            rx_buffer_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            error_summary_flag <= 1'b0;
            rx_irq_request <= 1'b0;
        end else begin
            rx_irq_request <= 1'b0;
            if (rx_done && rx_keep) begin
                rx_buffer_data <= rx_shift;
                rx_buffer_full_flag <= 1'b1;
                rx_irq_request <= !rx_buffer_full_flag || rx_buffer_low_read;
                overrun_flag <= rx_buffer_full_flag && !rx_buffer_low_read;
                framing_error_flag <= rx_frm_bad;
                parity_error_flag <= rx_par_bad;
                error_summary_flag <= (rx_buffer_full_flag && !rx_buffer_low_read)
                                      || rx_frm_bad || rx_par_bad;
            end else if (rx_buffer_low_read || !rx_enable_flag) begin
                rx_buffer_full_flag <= rx_buffer_full_flag && !rx_buffer_low_read;
                overrun_flag <= 1'b0;
                framing_error_flag <= 1'b0;
                parity_error_flag <= 1'b0;
                error_summary_flag <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            receive_ready_output <= 1'b1;
        end else if (!handshake_sel || !rx_enable_flag) begin
            receive_ready_output <= 1'b1;
        end else if (rx_phase != aspsl_pkg::ASPSL_IDLE) begin
            receive_ready_output <= 1'b1;
        end else begin
            receive_ready_output <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/aspsl_regs.svh
// Purpose: Constants for the asynchronous serial port with sleep
// Assumes: Included by bare name
// Notes: Bit positions and length codes of mode bits, timing constants
`ifndef ASPSL_REGS_SVH
`define ASPSL_REGS_SVH
// ==========================================
// Mode bits
`define ASPSL_MODE_STOP2 4
`define ASPSL_MODE_EVEN 5
`define ASPSL_MODE_PAREN 6
`define ASPSL_MODE_SLEEP 7
`define ASPSL_MODE_LEN_7 3'h4
`define ASPSL_MODE_LEN_8 3'h5
`define ASPSL_MODE_LEN_9 3'h6
// ==========================================
// Timing
`define ASPSL_OVERSAMPLE 5'h10
`define ASPSL_HALF_BIT 4'h7
`define ASPSL_LAST_TICK 4'hF
`endif

// >>> hdl/aspsl_pkg.sv
// Purpose: Types for the asynchronous serial port with sleep
// Assumes: Nothing
// Notes: State enumerations only
package aspsl_pkg;
    // ==========================================
    // Transmit and receive phases
    typedef enum logic [2:0] {
        ASPSL_IDLE,
        ASPSL_START,
        ASPSL_DATA,
        ASPSL_PARITY,
        ASPSL_STOP
    } aspsl_phase_t;
endpackage

// >>> dv/aspsl_top_asserts.sv
// Purpose: Port checks for the serial port
// Assumes: Frame length checked on the internal clock only
// Notes: Bound to aspsl_top below
`timescale 1ns/10ps
`default_nettype none
module aspsl_asserts (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] mode_reg,
    input wire logic handshake_sel,
    input wire logic tx_enable_flag,
    input wire logic rx_enable_flag,
    input wire logic ext_clk_sel,
    input wire logic [7:0] bit_rate_value,
    input wire logic rx_buffer_low_read,
    input wire logic send_permit_input,
    input wire logic serial_out_pin,
    input wire logic tx_buffer_empty_flag,
    input wire logic tx_shift_empty_flag,
    input wire logic frame_end_timing,
    input wire logic rx_buffer_full_flag,
    input wire logic overrun_flag,
    input wire logic framing_error_flag,
    input wire logic parity_error_flag,
    input wire logic error_summary_flag,
    input wire logic tx_irq_request,
    input wire logic rx_irq_request
);
    logic go;
    logic [3:0] nbits;
    logic [15:0] lo_cnt;
    logic [15:0] frame_cyc;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // ========
    // Start condition and frame length
    assign go = frame_end_timing && tx_enable_flag && !tx_buffer_empty_flag
        && (handshake_sel || !send_permit_input);
    assign nbits = 4'h2 + {3'h0, mode_reg[6]} + {3'h0, mode_reg[4]}
        + (mode_reg[2:0] == 3'h4 ? 4'h7 : mode_reg[2:0] == 3'h6 ? 4'h9 : 4'h8);
    assign frame_cyc = 16'(nbits) * 16'h0010 * (16'(bit_rate_value) + 16'h0001);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lo_cnt <= 16'h0000;
        end else begin
            lo_cnt <= frame_end_timing ? 16'h0000 : lo_cnt + 16'h0001;
        end
    end
    // ========
    // Assertions
    AST_TX_START: assert property (go |=>
        !serial_out_pin && !frame_end_timing && !tx_shift_empty_flag) else $error("no start");
    AST_TX_IDLE: assert property (frame_end_timing && !go |=> frame_end_timing)
        else $error("start without condition");
    AST_TX_IRQ: assert property (tx_irq_request == $rose(tx_buffer_empty_flag))
        else $error("tx request mismatch");
    AST_SHIFT_EMPTY: assert property ($rose(frame_end_timing) ##1 frame_end_timing
        |-> tx_shift_empty_flag) else $error("shift empty late");
    AST_FRAME_LEN: assert property (!ext_clk_sel && $rose(frame_end_timing) |->
        lo_cnt + 16'h0010 >= frame_cyc && lo_cnt <= frame_cyc + 16'h0010)
        else $error("frame length wrong");
    AST_ERR_SUM: assert property (error_summary_flag ==
        (overrun_flag || framing_error_flag || parity_error_flag)) else $error("summary wrong");
    AST_RX_IRQ: assert property ($rose(rx_buffer_full_flag) |-> rx_irq_request)
        else $error("rx request missing");
    AST_RD_CLEAR: assert property (rx_buffer_low_read |=>
        rx_irq_request || !(rx_buffer_full_flag || error_summary_flag))
        else $error("read did not clear");
    AST_RX_OFF: assert property (!rx_enable_flag |=> !error_summary_flag)
        else $error("disable did not clear");
    cover property (go);
    cover property ($rose(overrun_flag));
    cover property ($rose(rx_buffer_full_flag));
endmodule
bind aspsl_top aspsl_asserts i_chk (
    .sys_clk, .nrst, .mode_reg, .handshake_sel, .tx_enable_flag, .rx_enable_flag,
    .ext_clk_sel, .bit_rate_value, .rx_buffer_low_read, .send_permit_input,
    .serial_out_pin, .tx_buffer_empty_flag, .tx_shift_empty_flag, .frame_end_timing,
    .rx_buffer_full_flag, .overrun_flag, .framing_error_flag, .parity_error_flag,
    .error_summary_flag, .tx_irq_request, .rx_irq_request
);
`default_nettype wire

// >>> dv/aspsl_remote.sv
// Purpose: Remote serial port on the far side of the lines
// Assumes: BIT clock cycles a bit, same format as the device
// Notes: Frames hold start, data, parity, stop from bit 0 up
`timescale 1ns/10ps
`default_nettype none
module aspsl_remote #(
    parameter int BIT = 32
) (
    input wire logic sys_clk,
    input wire logic line_in,
    output logic line_out,
    output logic permit_n
);
    logic [12:0] got;
    int rxn;
    int nrx;
    initial begin
        line_out = 1'b1;
        permit_n = 1'b0;
        rxn = 10;
        nrx = 0;
    end
    // ========
    // Sender, line idles high
    task automatic send(input logic [12:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_out = f[i];
            repeat (BIT) @(negedge sys_clk);
        end
        line_out = 1'b1;
    endtask
    // Permit low only while able to accept
    task automatic hold(input logic busy);
        @(negedge sys_clk);
        permit_n = busy;
    endtask
    // ========
    // Receiver samples mid bit
    always begin
        @(negedge line_in);
        got = 13'h1FFF;
        repeat (BIT / 2) @(negedge sys_clk);
        for (int i = 0; i < rxn; i++) begin
            got[i] = line_in;
            if (i < rxn - 1) begin
                repeat (BIT) @(negedge sys_clk);
            end
        end
        nrx++;
    end
endmodule
`default_nettype wire

// >>> dv/aspsl_top_tb.sv
// Purpose: Self-checking bench for the serial port
// Assumes: 32 cycles a bit, internal clock with divider 1 or external ticks
// Notes: Inputs change on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module aspsl_top_tb;
    localparam int BIT = 32;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] mode_reg = 8'h05;
    logic handshake_sel = 1'b1;
    logic tx_enable_flag = 1'b1;
    logic rx_enable_flag = 1'b0;
    logic ext_clk_sel = 1'b0;
    logic ext_clk_tick = 1'b0;
    logic [7:0] bit_rate_value = 8'h01;
    logic [8:0] tx_buffer_data = 9'h000;
    logic tx_buffer_write = 1'b0;
    logic rx_buffer_low_read = 1'b0;
    logic send_permit_input, serial_in_pin, serial_out_pin, receive_ready_output;
    logic tx_buffer_empty_flag, tx_shift_empty_flag, frame_end_timing, rx_buffer_full_flag;
    logic overrun_flag, framing_error_flag, parity_error_flag, error_summary_flag;
    logic tx_irq_request, rx_irq_request;
    logic [8:0] rx_buffer_data;
    logic [12:0] f;
    int n;
    int n_mismatch = 0;
    int check_count = 0;
    aspsl_top i_dut (
        .sys_clk, .nrst, .mode_reg, .handshake_sel, .tx_enable_flag, .rx_enable_flag,
        .ext_clk_sel, .ext_clk_tick, .bit_rate_value, .tx_buffer_data, .tx_buffer_write,
        .rx_buffer_low_read, .send_permit_input, .serial_in_pin, .serial_out_pin,
        .receive_ready_output, .tx_buffer_empty_flag, .tx_shift_empty_flag,
        .frame_end_timing, .rx_buffer_data, .rx_buffer_full_flag, .overrun_flag,
        .framing_error_flag, .parity_error_flag, .error_summary_flag, .tx_irq_request,
        .rx_irq_request
    );
    aspsl_remote #(.BIT(BIT)) i_rem (
        .sys_clk, .line_in(serial_out_pin), .line_out(serial_in_pin),
        .permit_n(send_permit_input)
    );
    always #5 sys_clk = ~sys_clk;
    // External source ticks every other cycle
    always @(negedge sys_clk) begin
        ext_clk_tick <= ~ext_clk_tick;
    end
    // ========
    // Helpers
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge sys_clk);
    endtask
    task automatic frm(input logic [8:0] d, input int bad);
        logic p;
        int nb;
        nb = mode_reg[2:0] == 3'h4 ? 7 : mode_reg[2:0] == 3'h6 ? 9 : 8;
        p = ~mode_reg[5];
        f = 13'h1FFE;
        for (int k = 0; k < nb; k++) begin
            f[k + 1] = d[k];
            p = p ^ d[k];
        end
        if (mode_reg[6]) begin
            f[nb + 1] = p ^ (bad == 1);
        end
        n = nb + 2 + mode_reg[6] + mode_reg[4];
        if (bad == 2) begin
            f[n - 2] = 1'b0;
        end
        i_rem.rxn = n;
    endtask
    task automatic wr(input logic [8:0] d);
        tx_buffer_data = d;
        tx_buffer_write = 1'b1;
        tick(1);
        tx_buffer_write = 1'b0;
    endtask
    task automatic rd();
        rx_buffer_low_read = 1'b1;
        tick(1);
        rx_buffer_low_read = 1'b0;
        tick(1);
    endtask
    task automatic wait_rx(input int c);
        for (int i = 0; i < 1000 && i_rem.nrx < c; i++) begin
            tick(1);
        end
        chk(i_rem.got, f);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ========
    // Scenarios
    task automatic t_tx();
        logic [7:0] md [4] = '{8'h05, 8'h44, 8'h76, 8'h15};
        chk({serial_out_pin, receive_ready_output, frame_end_timing}, 7);
        for (int i = 0; i < 4; i++) begin
            mode_reg = md[i];
            frm(9'h1A5 - 9'(i), 0);
            wr(9'h1A5 - 9'(i));
            chk(tx_buffer_empty_flag, 0);
            wait_rx(i_rem.nrx + 1);
            tick(BIT);
        end
        $display("t_tx done");
    endtask
    task automatic t_stream();
        logic gap;
        int c;
        gap = 1'b0;
        c = i_rem.nrx;
        mode_reg = 8'h05;
        frm(9'h03C, 0);
        wr(9'h03C);
        for (int i = 0; i < 9 && !tx_buffer_empty_flag; i++) begin
            tick(1);
        end
        frm(9'h0C3, 0);
        wr(9'h0C3);
        for (int i = 0; i < 1000 && i_rem.nrx < c + 2; i++) begin
            gap = gap | tx_shift_empty_flag;
            if (tx_buffer_empty_flag) begin
                tx_enable_flag = 1'b0;
            end
            tick(1);
        end
        chk(gap, 0);
        chk(i_rem.got, f);
        tick(BIT);
        frm(9'h0E7, 0);
        wr(9'h0E7);
        tick(BIT * 3);
        chk(frame_end_timing, 1);
        handshake_sel = 1'b0;
        i_rem.hold(1'b1);
        tx_enable_flag = 1'b1;
        tick(BIT * 3);
        chk(frame_end_timing, 1);
        i_rem.hold(1'b0);
        for (int i = 0; i < 9 && frame_end_timing; i++) begin
            tick(1);
        end
        i_rem.hold(1'b1);
        wait_rx(c + 3);
        i_rem.hold(1'b0);
        handshake_sel = 1'b1;
        tick(BIT);
        $display("t_stream done");
    endtask
    task automatic t_ext();
        ext_clk_sel = 1'b1;
        bit_rate_value = 8'h00;
        mode_reg = 8'h05;
        tick(BIT);
        frm(9'h05A, 0);
        wr(9'h05A);
        wait_rx(i_rem.nrx + 1);
        tick(BIT);
        chk({tx_shift_empty_flag, tx_buffer_empty_flag}, 3);
        ext_clk_sel = 1'b0;
        bit_rate_value = 8'h01;
        tick(BIT);
        $display("t_ext done");
    endtask
    task automatic t_rx();
        mode_reg = 8'h05;
        rx_enable_flag = 1'b1;
        tick(2);
        chk(receive_ready_output, 0);
        frm(9'h03C, 0);
        fork
            i_rem.send(f, n);
            begin
                tick(BIT * 2);
                chk(receive_ready_output, 1);
            end
        join
        tick(2);
        chk({rx_buffer_full_flag, error_summary_flag, rx_buffer_data}, 13'h043C);
        frm(9'h055, 0);
        i_rem.send(f, n);
        tick(2);
        chk({rx_buffer_full_flag, overrun_flag, error_summary_flag, rx_buffer_data},
            13'h0E55);
        rd();
        chk({rx_buffer_full_flag, error_summary_flag}, 0);
        for (int b = 0; b < 3; b++) begin
            mode_reg = b == 2 ? 8'h15 : 8'h45;
            frm(9'h0A5, b);
            i_rem.send(f, n);
            tick(2);
            chk({rx_buffer_full_flag, framing_error_flag, parity_error_flag}, 4 + b);
            if (b == 2) begin
                rx_enable_flag = 1'b0;
                tick(2);
                chk(error_summary_flag, 0);
                rx_enable_flag = 1'b1;
            end
            rd();
        end
        $display("t_rx done");
    endtask
    task automatic t_sleep();
        mode_reg = 8'h85;
        frm(9'h012, 0);
        i_rem.send(f, n);
        tick(2);
        chk(rx_buffer_full_flag, 0);
        frm(9'h092, 0);
        i_rem.send(f, n);
        tick(2);
        chk({rx_buffer_full_flag, rx_buffer_data}, 13'h0292);
        mode_reg = 8'h86;
        frm(9'h0FF, 0);
        i_rem.send(f, n);
        tick(2);
        chk({rx_buffer_full_flag, overrun_flag, rx_buffer_data}, 13'h0492);
        $display("t_sleep done");
    endtask
    initial begin
        tick(12);
        nrst = 1'b1;
        tick(2);
        t_tx();
        t_stream();
        t_ext();
        t_rx();
        t_sleep();
        close_out();
    end
    initial begin
        #500000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
